// File: include/t2c_regs.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * sixteen-bit capture / reload / baud / clock-out timer.
 * Assumes a 32-bit AHB-Lite bus where each register takes one aligned word,
 * and a core clock that is the oscillator of the timer.
 */
`ifndef T2C_REGS_VH
`define T2C_REGS_VH

`define T2C_OFF_CTRL 8'h00
`define T2C_OFF_MODE 8'h04
`define T2C_OFF_CNT_LO 8'h08
`define T2C_OFF_CNT_HI 8'h0c
`define T2C_OFF_RLD_LO 8'h10
`define T2C_OFF_RLD_HI 8'h14

`define T2C_CTRL_OVF 7
`define T2C_CTRL_EXF 6
`define T2C_CTRL_RCLK 5
`define T2C_CTRL_TRANSMIT_CLOCK_SELECT 4
`define T2C_CTRL_EXEN 3
`define T2C_CTRL_RUN 2
`define T2C_CTRL_CT 1
`define T2C_CTRL_CPRL 0
`define T2C_MODE_DOWN_COUNT_ENABLE 0
`define T2C_MODE_OE 1

`define T2C_CTRL_RESET 8'h00
`define T2C_MODE_RESET 8'h00
`define T2C_COUNT_HI_RESET 8'h00
`define T2C_COUNT_LO_RESET 8'h00
`define T2C_RELOAD_HI_RESET 8'h00
`define T2C_RELOAD_LO_RESET 8'h00

`define T2C_MACHINE_CLKS 4'd12
`define T2C_SAMPLE_PHASE 4'd9
`define T2C_UPDATE_PHASE 4'd4
`define T2C_BIT_DIVIDE 4'd15

`endif

// File: rtl/t2c_edge_sampler.v
/*
 * Samples one pin on a sampling strobe and reports a high-to-low change
 * between two successive samples.
 * Assumes the pin is synchronous to the core clock.
 */
`timescale 1ns/1ps
module t2c_edge_sampler (
   input wire core_clk_i,
   input wire rst_i,
   input wire sample_en_i,
   input wire pin_i,
   output wire level_o,
   output wire fall_o
);
   reg smp_reg;
   reg fall_reg;

   // The idle level is taken as high, so a pin held low out of reset shows a fall at the first sample.
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         smp_reg <= 1'b1;
         fall_reg <= 1'b0;
      end else if (sample_en_i) begin
         smp_reg <= pin_i;
         fall_reg <= smp_reg & ~pin_i;
      end else begin
         fall_reg <= 1'b0;
      end
   end

   assign level_o = smp_reg;
   assign fall_o = fall_reg;
endmodule

// File: rtl/t2c_timer.v
/*
 * Sixteen-bit timer with capture, auto-reload up/down, baud generation and
 * clock-out, reached over an AHB-Lite slave port.
 * Assumes the core clock is the oscillator, pins are synchronous to it,
 * and the serial port takes the one-cycle bit-rate ticks produced here.
 */
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "t2c_regs.vh"
module t2c_timer (
   input wire core_clk_i,
   input wire rst_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire [31:0] hrdata_o,
   output wire hreadyout_o,
   output wire hresp_o,
   input wire event_pin_i,
   output wire event_pin_o,
   output wire event_pin_oe_o,
   input wire trigger_pin_i,
   input wire timer1_overflow_i,
   input wire int_enable_i,
   output wire irq_o,
   output wire overflow_tick_o,
   output wire rx_bit_tick_o,
   output wire tx_bit_tick_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.

   reg [7:0] timer_control_reg;
   reg [7:0] timer_mode_reg;
   reg [7:0] count_high_byte_reg;
   reg [7:0] count_low_byte_reg;
   reg [7:0] capture_reload_high_reg;
   reg [7:0] capture_reload_low_reg;
   reg [3:0] phase_reg;
   reg evt_pend_reg;
   reg clk_out_reg;
   reg ovf_tick_reg;
   reg [3:0] rx_div_reg;
   reg [3:0] tx_div_reg;
   reg rx_tick_reg;
   reg tx_tick_reg;

   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg rd_wait_reg;
   reg [7:0] rd_addr_reg;
   reg [31:0] hrdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Machine-cycle and state-time strobes.

   wire sample_phase;
   wire update_phase;
   wire state_en;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_reg <= 4'h0;
      end else if (phase_reg == `T2C_MACHINE_CLKS - 4'd1) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'd1;
      end
   end

   assign sample_phase = (phase_reg == `T2C_SAMPLE_PHASE);
   assign update_phase = (phase_reg == `T2C_UPDATE_PHASE);
   assign state_en = phase_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling, once per machine cycle for both pins.

   wire evt_level;
   wire evt_fall;
   wire trig_level;
   wire trig_fall;

   t2c_edge_sampler u_event_sampler (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sample_en_i(sample_phase),
      .pin_i(event_pin_i),
      .level_o(evt_level),
      .fall_o(evt_fall)
   );

   t2c_edge_sampler u_trigger_sampler (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sample_en_i(sample_phase),
      .pin_i(trigger_pin_i),
      .level_o(trig_level),
      .fall_o(trig_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode.

   wire run_bit;
   wire timer_counter_select;
   wire capture_reload_select;
   wire external_trigger_enable;
   wire transmit_clock_select;
   wire receive_clock_select;
   wire down_count_enable;
   wire clock_output_enable;
   wire baud_mode;
   wire capture_mode;
   wire reload_mode;
   wire clkout_mode;
   wire updown_mode;
   wire [15:0] count_now;
   wire [15:0] reload_now;

   assign run_bit = timer_control_reg[`T2C_CTRL_RUN];
   assign timer_counter_select = timer_control_reg[`T2C_CTRL_CT];
   assign capture_reload_select = timer_control_reg[`T2C_CTRL_CPRL];
   assign external_trigger_enable = timer_control_reg[`T2C_CTRL_EXEN];
   assign transmit_clock_select = timer_control_reg[`T2C_CTRL_TRANSMIT_CLOCK_SELECT];
   assign receive_clock_select = timer_control_reg[`T2C_CTRL_RCLK];
   assign down_count_enable = timer_mode_reg[`T2C_MODE_DOWN_COUNT_ENABLE];
   assign clock_output_enable = timer_mode_reg[`T2C_MODE_OE];

   assign baud_mode = run_bit & (transmit_clock_select | receive_clock_select);
   assign capture_mode = run_bit & ~baud_mode & capture_reload_select;
   assign reload_mode = run_bit & ~baud_mode & ~capture_reload_select;
   assign clkout_mode = clock_output_enable & ~timer_counter_select;
   assign updown_mode = reload_mode & down_count_enable & ~clkout_mode;
   assign count_now = {count_high_byte_reg, count_low_byte_reg};
   assign reload_now = {capture_reload_high_reg, capture_reload_low_reg};

   ////////////////////////////////////////////////////////////////////////////
   // Count step. Baud with timer_counter_select clear and clock-out count on state times, so they share one
   // reload pair and cannot be set apart in frequency.

   reg inc_en;
   reg [15:0] count_next;
   reg ovf_set;
   reg exf_set;
   reg exf_toggle;
   reg capture_now;
   reg rollover;

   always @* begin
      inc_en = 1'b0;
      count_next = count_now;
      ovf_set = 1'b0;
      exf_set = 1'b0;
      exf_toggle = 1'b0;
      capture_now = 1'b0;
      rollover = 1'b0;
      if (run_bit) begin
         if (timer_counter_select) begin
            inc_en = evt_pend_reg & update_phase;
         end else if (baud_mode | clkout_mode) begin
            inc_en = state_en;
         end else begin
            inc_en = update_phase;
         end
      end
      if (inc_en) begin
         if (updown_mode & ~trig_level) begin
            if (count_now == reload_now) begin
               count_next = 16'hffff;
               ovf_set = 1'b1;
               exf_toggle = 1'b1;
            end else begin
               count_next = count_now - 16'd1;
            end
         end else if (count_now == 16'hffff) begin
            rollover = 1'b1;
            if (capture_mode) begin
               count_next = 16'h0000;
               ovf_set = ~clkout_mode;
            end else begin
               count_next = reload_now;
               ovf_set = ~baud_mode & ~clkout_mode;
               exf_toggle = updown_mode;
            end
         end else begin
            count_next = count_now + 16'd1;
         end
      end
      if (run_bit & external_trigger_enable & trig_fall) begin
         if (capture_mode) begin
            capture_now = 1'b1;
            exf_set = 1'b1;
         end else if (baud_mode) begin
            exf_set = 1'b1;
         end else if (~updown_mode) begin
            count_next = reload_now;
            exf_set = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave. Writes land at the end of the data phase; reads add one wait
   // state so a read right after a write returns the written value.

   wire addr_phase;
   reg [7:0] wr_byte;
   reg [7:0] rd_byte;

   assign addr_phase = hsel_i & htrans_i[1] & hready_i;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_wait_reg <= 1'b0;
         rd_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_phase & hwrite_i;
         rd_wait_reg <= addr_phase & ~hwrite_i;
         if (addr_phase) begin
            wr_addr_reg <= haddr_i[7:0];
            rd_addr_reg <= haddr_i[7:0];
         end
         if (rd_wait_reg) begin
            hrdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   always @* begin
      wr_byte = hwdata_i[7:0];
      case (rd_addr_reg)
         `T2C_OFF_CTRL: rd_byte = timer_control_reg;
         `T2C_OFF_MODE: rd_byte = {6'h00, timer_mode_reg[1:0]};
         `T2C_OFF_CNT_LO: rd_byte = count_low_byte_reg;
         `T2C_OFF_CNT_HI: rd_byte = count_high_byte_reg;
         `T2C_OFF_RLD_LO: rd_byte = capture_reload_low_reg;
         `T2C_OFF_RLD_HI: rd_byte = capture_reload_high_reg;
         default: rd_byte = 8'h00;
      endcase
   end

   assign hrdata_o = hrdata_reg;
   assign hreadyout_o = ~rd_wait_reg;
   assign hresp_o = 1'b0;

   wire wr_ctrl;
   wire wr_mode;
   wire wr_cnt_lo;
   wire wr_cnt_hi;
   wire wr_rld_lo;
   wire wr_rld_hi;

   assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `T2C_OFF_CTRL);
   assign wr_mode = wr_pend_reg & (wr_addr_reg == `T2C_OFF_MODE);
   assign wr_cnt_lo = wr_pend_reg & (wr_addr_reg == `T2C_OFF_CNT_LO);
   assign wr_cnt_hi = wr_pend_reg & (wr_addr_reg == `T2C_OFF_CNT_HI);
   assign wr_rld_lo = wr_pend_reg & (wr_addr_reg == `T2C_OFF_RLD_LO);
   assign wr_rld_hi = wr_pend_reg & (wr_addr_reg == `T2C_OFF_RLD_HI);

   ////////////////////////////////////////////////////////////////////////////
   // Control and flags. A hardware set beats a software clear in the same
   // cycle, so no overflow or trigger event is ever lost.

   reg [7:0] ctrl_base;

   always @* begin
      ctrl_base = wr_ctrl ? wr_byte : timer_control_reg;
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_control_reg <= `T2C_CTRL_RESET;
         timer_mode_reg <= `T2C_MODE_RESET;
      end else begin
         timer_control_reg[5:0] <= ctrl_base[5:0];
         timer_control_reg[`T2C_CTRL_OVF] <= ctrl_base[`T2C_CTRL_OVF] | ovf_set;
         timer_control_reg[`T2C_CTRL_EXF] <= (ctrl_base[`T2C_CTRL_EXF] ^ exf_toggle) | exf_set;
         if (wr_mode) begin
            timer_mode_reg <= {6'h00, wr_byte[1:0]};
         end
      end
   end

   // Software writes to the count or reload bytes take priority over the
   // hardware; while the timer runs that write may collide with a reload.
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_high_byte_reg <= `T2C_COUNT_HI_RESET;
         count_low_byte_reg <= `T2C_COUNT_LO_RESET;
         capture_reload_high_reg <= `T2C_RELOAD_HI_RESET;
         capture_reload_low_reg <= `T2C_RELOAD_LO_RESET;
      end else begin
         count_high_byte_reg <= wr_cnt_hi ? wr_byte : count_next[15:8];
         count_low_byte_reg <= wr_cnt_lo ? wr_byte : count_next[7:0];
         if (wr_rld_hi) begin
            capture_reload_high_reg <= wr_byte;
         end else if (capture_now) begin
            capture_reload_high_reg <= count_high_byte_reg;
         end
         if (wr_rld_lo) begin
            capture_reload_low_reg <= wr_byte;
         end else if (capture_now) begin
            capture_reload_low_reg <= count_low_byte_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event count pending: the fall seen at the sampling phase is counted at the
   // update phase of the next machine cycle.

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_pend_reg <= 1'b0;
      end else if (evt_fall) begin
         evt_pend_reg <= 1'b1;
      end else if (update_phase) begin
         evt_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock-out: the pin toggles on each rollover, giving half the overflow rate.

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_out_reg <= 1'b0;
      end else if (clkout_mode & rollover) begin
         clk_out_reg <= ~clk_out_reg;
      end
   end

   assign event_pin_o = clk_out_reg;
   assign event_pin_oe_o = clkout_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Serial clocks. Each direction divides its chosen overflow source by
   // sixteen; the source changes without resetting the divider.

   wire t2_ovf;
   wire rx_src;
   wire tx_src;

   assign t2_ovf = baud_mode & rollover;
   assign rx_src = receive_clock_select ? t2_ovf : timer1_overflow_i;
   assign tx_src = transmit_clock_select ? t2_ovf : timer1_overflow_i;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ovf_tick_reg <= 1'b0;
         rx_div_reg <= 4'h0;
         tx_div_reg <= 4'h0;
         rx_tick_reg <= 1'b0;
         tx_tick_reg <= 1'b0;
      end else begin
         ovf_tick_reg <= t2_ovf;
         rx_tick_reg <= rx_src & (rx_div_reg == `T2C_BIT_DIVIDE);
         tx_tick_reg <= tx_src & (tx_div_reg == `T2C_BIT_DIVIDE);
         if (rx_src) begin
            rx_div_reg <= rx_div_reg + 4'd1;
         end
         if (tx_src) begin
            tx_div_reg <= tx_div_reg + 4'd1;
         end
      end
   end

   assign overflow_tick_o = ovf_tick_reg;
   assign rx_bit_tick_o = rx_tick_reg;
   assign tx_bit_tick_o = tx_tick_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request to the processor's interrupt controller.

   assign irq_o = int_enable_i & (timer_control_reg[`T2C_CTRL_OVF] |
                  (timer_control_reg[`T2C_CTRL_EXF] & ~down_count_enable));

endmodule

// File: test/t2c_pin_model.sv
/*
 * Far-side model of the timer's event and trigger pins.
 * Assumes each go request is one clock wide and is not repeated while busy_o is high.
 */
`timescale 1ns/1ps
module t2c_pin_model (
   input wire core_clk_i,
   input wire rst_i,
   input wire ev_go_i,
   input wire tr_go_i,
   input wire tr_low_i,
   input wire slow_i,
   output wire event_pin_o,
   output wire trigger_pin_o,
   output wire busy_o
);
   logic [5:0] ev_cnt_reg;
   logic [5:0] tr_cnt_reg;
   logic [5:0] len;

   ////////////////////////////////////////////////////////////////////////////
   // A fall holds low for 12 or 24 clocks, then high for 12, so every level
   // spans at least one machine cycle and is sampled at least once.
   assign len = slow_i ? 6'h24 : 6'h18;
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ev_cnt_reg <= 6'h00;
         tr_cnt_reg <= 6'h00;
      end else begin
         ev_cnt_reg <= ev_go_i ? len : ev_cnt_reg - {5'h00, ev_cnt_reg != 6'h00};
         tr_cnt_reg <= tr_go_i ? len : tr_cnt_reg - {5'h00, tr_cnt_reg != 6'h00};
      end
   end
   assign event_pin_o = ev_cnt_reg <= 6'h0c;
   assign trigger_pin_o = !tr_low_i && tr_cnt_reg <= 6'h0c;
   assign busy_o = (ev_cnt_reg | tr_cnt_reg) != 6'h00;
endmodule

// File: test/t2c_timer_assertions.sv
/*
 * Port-level checker for the t2c timer, bound to its top module.
 * Assumes hready_i is the timer's own hreadyout_o.
 */
`timescale 1ns/1ps
module t2c_timer_assertions (
   input wire core_clk_i,
   input wire rst_i,
   input wire hsel_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire event_pin_o,
   input wire event_pin_oe_o,
   input wire int_enable_i,
   input wire irq_o,
   input wire overflow_tick_o,
   input wire rx_bit_tick_o,
   input wire tx_bit_tick_o
);
   logic wr_dp_reg;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i)
         wr_dp_reg <= 1'b0;
      else
         wr_dp_reg <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence take_s;
      hsel_i && htrans_i[1] && hready_i;
   endsequence
   sequence rd_phase_s;
      !hreadyout_o ##1 hreadyout_o;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   read_wait_a: assert property (take_s ##0 !hwrite_i |=> rd_phase_s)
      else $error("read data phase not exactly one wait");
   write_fast_a: assert property (take_s ##0 hwrite_i |=> hreadyout_o)
      else $error("write data phase stalled");
   resp_okay_a: assert property (hresp_o == 1'b0 && hrdata_o[31:8] == 24'h000000)
      else $error("bad response or upper read bits");
   irq_gate_a: assert property (!int_enable_i |-> !irq_o)
      else $error("irq raised while disabled");
   // Flags clear only by software, except EXF toggling in up/down mode where irq masks it, so a falling request needs a write or a mask.
   irq_clear_a: assert property ($fell(irq_o) |-> $past(wr_dp_reg) || !int_enable_i)
      else $error("irq dropped without software");
   oe_source_a: assert property ($changed(event_pin_oe_o) |-> $past(wr_dp_reg))
      else $error("clock-out enable moved without a write");
   clk_half_a: assert property ($changed(event_pin_o) |=> $stable(event_pin_o))
      else $error("clock-out half period below two clocks");
   roll_space_a: assert property (overflow_tick_o |=> !overflow_tick_o)
      else $error("rollovers closer than one state time");
   tx_space_a: assert property (tx_bit_tick_o |=> !tx_bit_tick_o [*8])
      else $error("transmit bit ticks too close");
   rx_space_a: assert property (rx_bit_tick_o |=> !rx_bit_tick_o [*8])
      else $error("receive bit ticks too close");
endmodule

bind t2c_timer t2c_timer_assertions chk (.core_clk_i, .rst_i, .hsel_i, .htrans_i,
   .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .event_pin_o, .event_pin_oe_o,
   .int_enable_i, .irq_o, .overflow_tick_o, .rx_bit_tick_o, .tx_bit_tick_o);

// File: test/t2c_timer_tb.sv
/*
 * Self-checking bench for the t2c timer: AHB-Lite master tasks, pin model,
 * period monitors, random values and directed corner cases.
 * Assumes the timer answers OKAY and hready is its own hreadyout.
 */
`timescale 1ns/1ps
`include "t2c_regs.vh"
module t2c_timer_tb;
   logic clk, rst, hsel, hwrite, int_en, t1_ovf, ev_go, tr_go, tr_low, slow, ev_q;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, rdv, seed, cyc, bad_count, check_count, v, r, n;
   logic [31:0] t_last [4];
   logic [31:0] per [4];
   int rx_n, c;
   wire [31:0] hrdata;
   wire hready, hresp, ev_out, ev_oe, ev_mdl, tr_pin, irq, ovt, rxt, txt, busy;
   wire ev_pin = ev_oe ? ev_out : ev_mdl;
   wire [3:0] evs = {ovt, ev_out & ~ev_q, rxt, txt};

   t2c_timer DUT (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .event_pin_i(ev_pin), .event_pin_o(ev_out), .event_pin_oe_o(ev_oe),
      .trigger_pin_i(tr_pin), .timer1_overflow_i(t1_ovf), .int_enable_i(int_en),
      .irq_o(irq), .overflow_tick_o(ovt), .rx_bit_tick_o(rxt), .tx_bit_tick_o(txt));
   t2c_pin_model MDL (.core_clk_i(clk), .rst_i(rst), .ev_go_i(ev_go), .tr_go_i(tr_go),
      .tr_low_i(tr_low), .slow_i(slow), .event_pin_o(ev_mdl), .trigger_pin_o(tr_pin),
      .busy_o(busy));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count != 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Entered just after a rising edge; a stalled slave is cut off by the timeout.
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rdv, e);
   endtask

   task w16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 8'h04, d[15:8]);
   endtask

   task r16(input logic [7:0] a, input logic [15:0] e);
      rc(a, {24'h000000, e[7:0]});
      rc(a + 8'h04, {24'h000000, e[15:8]});
   endtask

   // One falling edge on the trigger (t high) or event pin, then time to settle.
   task pin(input logic t);
      while (busy === 1'b1) @(posedge clk);
      if (t)
         tr_go <= 1'b1;
      else
         ev_go <= 1'b1;
      @(posedge clk);
      tr_go <= 1'b0;
      ev_go <= 1'b0;
      tick(48);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      ev_q <= ev_out;
      if (rxt)
         rx_n <= rx_n + 1;
      for (int k = 0; k < 4; k++) begin
         if (evs[k]) begin
            per[k] <= cyc - t_last[k];
            t_last[k] <= cyc;
         end
      end
      if (cyc == 32'd60000) begin
         bad_count = bad_count + 1;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h46;
      cyc = 0;
      bad_count = 0;
      check_count = 0;
      rx_n = 0;
      rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {t1_ovf, ev_go, tr_go, tr_low, slow, ev_q} = '0;
      int_en = 1'b1;
      tick(16);
      rst <= 1'b0;
      tick(1);
      for (int i = 0; i < 8; i++) rc(8'(i * 4), 32'h0);
      for (int i = 2; i < 6; i++) begin
         v = rnd();
         wr(8'(i * 4), v[7:0]);
         rc(8'(i * 4), {24'h000000, v[7:0]});
      end
      wr(`T2C_OFF_MODE, 8'hfc);
      rc(`T2C_OFF_MODE, 32'h0);
      wr(8'h18, 8'hff);
      rc(8'h18, 32'h0);
      w16(`T2C_OFF_CNT_LO, 16'h0000);
      wr(`T2C_OFF_CTRL, 8'h04);
      tick(120);
      wr(`T2C_OFF_CTRL, 8'h00);
      xfer(1'b0, `T2C_OFF_CNT_LO, 8'h00);
      chk({31'h0, rdv[7:0] inside {8'd10, 8'd11}}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         v = i ? 32'hffff : rnd();
         slow <= v[0];
         w16(`T2C_OFF_CNT_LO, v[15:0]);
         wr(`T2C_OFF_CTRL, 8'h0f);
         pin(1'b1);
         pin(1'b0);
         rc(`T2C_OFF_CTRL, {24'h0, v[15:0] == 16'hffff, 7'h4f});
         chk({31'h0, irq}, 32'h1);
         wr(`T2C_OFF_CTRL, 8'h00);
         r16(`T2C_OFF_RLD_LO, v[15:0]);
         r16(`T2C_OFF_CNT_LO, v[15:0] + 16'h1);
      end
      r = rnd();
      w16(`T2C_OFF_RLD_LO, r[15:0]);
      w16(`T2C_OFF_CNT_LO, 16'hffff);
      wr(`T2C_OFF_CTRL, 8'h0e);
      pin(1'b0);
      rc(`T2C_OFF_CTRL, 32'h8e);
      int_en <= 1'b0;
      tick(1);
      chk({31'h0, irq}, 32'h0);
      int_en <= 1'b1;
      wr(`T2C_OFF_CTRL, 8'h00);
      w16(`T2C_OFF_CNT_LO, 16'h0005);
      wr(`T2C_OFF_CTRL, 8'h0e);
      pin(1'b1);
      rc(`T2C_OFF_CTRL, 32'h4e);
      wr(`T2C_OFF_CTRL, 8'h00);
      r16(`T2C_OFF_CNT_LO, r[15:0]);
      wr(`T2C_OFF_MODE, 8'h01);
      w16(`T2C_OFF_RLD_LO, 16'h0010);
      w16(`T2C_OFF_CNT_LO, 16'h0011);
      tr_low <= 1'b1;
      wr(`T2C_OFF_CTRL, 8'h06);
      pin(1'b0);
      pin(1'b0);
      rc(`T2C_OFF_CTRL, 32'hc6);
      wr(`T2C_OFF_CTRL, 8'h46);
      tick(1);
      chk({31'h0, irq}, 32'h0);
      tr_low <= 1'b0;
      tick(24);
      pin(1'b0);
      rc(`T2C_OFF_CTRL, 32'h86);
      wr(`T2C_OFF_CTRL, 8'h00);
      r16(`T2C_OFF_CNT_LO, 16'h0010);
      r = rnd();
      n = 32'd16 - {28'h0, r[3:0]};
      w16(`T2C_OFF_RLD_LO, {12'hfff, r[3:0]});
      w16(`T2C_OFF_CNT_LO, {12'hfff, r[3:0]});
      wr(`T2C_OFF_MODE, 8'h02);
      // Count and reload stay untouched until the timer is stopped again.
      wr(`T2C_OFF_CTRL, 8'h3c);
      tick(100 * n + 20);
      chk(per[0], 32 * n);
      chk(per[1], 32 * n);
      chk(per[2], 4 * n);
      chk(per[3], 2 * n);
      chk({31'h0, ev_oe}, 32'h1);
      pin(1'b1);
      rc(`T2C_OFF_CTRL, 32'h7c);
      wr(`T2C_OFF_CTRL, 8'h14);
      // A receive tick from the old source may still be in flight for two edges.
      tick(2);
      c = rx_n;
      for (int i = 0; i < 32; i++) begin
         r = rnd();
         t1_ovf <= 1'b1;
         tick(1);
         t1_ovf <= 1'b0;
         tick(3 + r[1:0]);
      end
      tick(4);
      chk(32'(rx_n - c), 32'h2);
      chk(per[2], 4 * n);
      wr(`T2C_OFF_CTRL, 8'h00);
      wr(`T2C_OFF_MODE, 8'h00);
      tick(2);
      chk({31'h0, ev_oe}, 32'h0);
      end_of_test();
   end
endmodule
